/* File: dao_top.sv */
// dual converter output port with AHB-Lite control registers
`timescale 1ns/1ps
module dao_top
  import dao_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic sample_clock_first,
  input wire logic sample_clock_second,
  input wire logic [DAO_IN_W-1:0] analog_code_first,
  input wire logic [DAO_IN_W-1:0] analog_code_second,
  input wire logic output_swap_select,
  input wire logic power_down_select_first,
  input wire logic power_down_select_second,
  input wire logic output_enable_n_first,
  input wire logic output_enable_n_second,
  output logic [DAO_RES_W-1:0] result_bus_first_o,
  output logic result_bus_first_oe,
  output logic over_range_flag_first_o,
  output logic over_range_flag_first_oe,
  output logic [DAO_RES_W-1:0] result_bus_second_o,
  output logic result_bus_second_oe,
  output logic over_range_flag_second_o,
  output logic over_range_flag_second_oe
);
  logic [1:0] clk_s;
  logic [1:0] clk_prev_q;
  logic [1:0] sample_pulse;
  logic [DAO_IN_W-1:0] code_first_s;
  logic [DAO_IN_W-1:0] code_second_s;
  logic swap_s;
  logic [1:0] pdn_s;
  logic [1:0] oen_s;
  logic [1:0] fmt_q;
  logic twos_fmt;
  logic stab_on;
  logic [DAO_RES_W-1:0] res_first;
  logic [DAO_RES_W-1:0] res_second;
  logic ovr_first;
  logic ovr_second;
  logic drive_first;
  logic drive_second;
  logic conv_first;
  logic conv_second;
  dao_state_t state_first;
  dao_state_t state_second;
  logic [1:0] ovr_hit_q;
  logic [DAO_CNT_W-1:0] cnt_first_q;
  logic [DAO_CNT_W-1:0] cnt_second_q;
  logic dp_write_q;
  logic [7:0] dp_addr_q;
  logic ap_valid;
  logic [31:0] rd_d;
  logic [31:0] status_word;
  logic wr_ctrl;
  logic wr_status;
  logic oe_first_d;
  logic oe_second_d;

  // the sample clock, code and control pins are asynchronous to hclk; the AHB-Lite pins are not
  // code words are synchronised bit by bit; they are read only at a sample
  // edge, three cycles after the pin rose, so the source must hold them steady
  dao_sync #(.W(2)) u_sync_clk (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({sample_clock_second, sample_clock_first}),
    .q(clk_s)
  );

  dao_sync #(.W(DAO_IN_W)) u_sync_code_first (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(analog_code_first),
    .q(code_first_s)
  );

  dao_sync #(.W(DAO_IN_W)) u_sync_code_second (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(analog_code_second),
    .q(code_second_s)
  );

  dao_sync #(.W(5)) u_sync_ctl (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({output_swap_select, output_enable_n_second, output_enable_n_first,
        power_down_select_second, power_down_select_first}),
    .q({swap_s, oen_s, pdn_s})
  );

  // rising edge of each channel's own sample clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_prev_q <= '0;
    end else begin
      clk_prev_q <= clk_s;
    end
  end

  assign sample_pulse = clk_s & ~clk_prev_q;

  // format level picks code format and stabilizer
  always_comb begin
    case (fmt_q)
      DAO_FMT_GND: begin
        twos_fmt = 1'b0;
        stab_on = 1'b0;
      end
      DAO_FMT_THIRD: begin
        twos_fmt = 1'b0;
        stab_on = 1'b1;
      end
      DAO_FMT_TWO_THIRDS: begin
        twos_fmt = 1'b1;
        stab_on = 1'b1;
      end
      default: begin
        twos_fmt = 1'b1;
        stab_on = 1'b0;
      end
    endcase
  end

  dao_chan u_chan_first (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_pulse(sample_pulse[0]),
    .analog_code(code_first_s),
    .power_down(pdn_s[0]),
    .output_enable_n(oen_s[0]),
    .twos_fmt(twos_fmt),
    .result_q(res_first),
    .over_range_q(ovr_first),
    .drive(drive_first),
    .converting(conv_first),
    .state_q(state_first)
  );

  dao_chan u_chan_second (
    .hclk(hclk),
    .hresetn(hresetn),
    .sample_pulse(sample_pulse[1]),
    .analog_code(code_second_s),
    .power_down(pdn_s[1]),
    .output_enable_n(oen_s[1]),
    .twos_fmt(twos_fmt),
    .result_q(res_second),
    .over_range_q(ovr_second),
    .drive(drive_second),
    .converting(conv_second),
    .state_q(state_second)
  );

  // bit 9 of each bus is the most significant bit
  // data flops reload every cycle, so a swap change shows within one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_bus_first_o <= '0;
      result_bus_second_o <= '0;
      over_range_flag_first_o <= 1'b0;
      over_range_flag_second_o <= 1'b0;
    end else if (swap_s) begin
      result_bus_first_o <= res_first;
      over_range_flag_first_o <= ovr_first;
      result_bus_second_o <= res_second;
      over_range_flag_second_o <= ovr_second;
    end else begin
      // buses crossed, flag travels with data
      result_bus_first_o <= res_second;
      over_range_flag_first_o <= ovr_second;
      result_bus_second_o <= res_first;
      over_range_flag_second_o <= ovr_first;
    end
  end

  // with swap tied to the clocks the bus alternates each half period
  // enable lags the pins by about four cycles of hclk
  assign oe_first_d = swap_s ? drive_first : drive_second;
  assign oe_second_d = swap_s ? drive_second : drive_first;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_bus_first_oe <= 1'b0;
      over_range_flag_first_oe <= 1'b0;
      result_bus_second_oe <= 1'b0;
      over_range_flag_second_oe <= 1'b0;
    end else begin
      // enable follows the channel that owns the bus
      result_bus_first_oe <= oe_first_d;
      over_range_flag_first_oe <= oe_first_d;
      result_bus_second_oe <= oe_second_d;
      over_range_flag_second_oe <= oe_second_d;
    end
  end

  // conversions seen per channel
  // 16-bit counts wrap silently; software must read often enough
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_first_q <= '0;
      cnt_second_q <= '0;
    end else begin
      if (conv_first && sample_pulse[0]) begin
        cnt_first_q <= cnt_first_q + 1'b1;
      end
      if (conv_second && sample_pulse[1]) begin
        cnt_second_q <= cnt_second_q + 1'b1;
      end
    end
  end

  // ---------------- AHB-Lite slave ----------------
  assign hreadyout = 1'b1;
  assign hresp = DAO_HRESP_OKAY;
  // no wait states; a sequential beat is taken like a single one
  assign ap_valid = hsel && hready && (htrans == DAO_HTRANS_NONSEQ || htrans == 2'h3);

  // write strobes decoded once, in the data phase
  assign wr_ctrl = dp_write_q && (dp_addr_q == DAO_REG_CTRL);
  assign wr_status = dp_write_q && (dp_addr_q == DAO_REG_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_q <= 1'b0;
      dp_addr_q <= '0;
    end else begin
      dp_write_q <= ap_valid && hwrite;
      dp_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_q <= DAO_FMT_RESET;
    end else if (wr_ctrl) begin
      fmt_q <= hwdata[1:0];
    end
  end

  // sticky over-range seen; write one clears, a new hit wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovr_hit_q <= '0;
    end else begin
      if (ovr_first) begin
        ovr_hit_q[0] <= 1'b1;
      end else if (wr_status && hwdata[DAO_ST_OVR_FIRST]) begin
        ovr_hit_q[0] <= 1'b0;
      end
      if (ovr_second) begin
        ovr_hit_q[1] <= 1'b1;
      end else if (wr_status && hwdata[DAO_ST_OVR_SECOND]) begin
        ovr_hit_q[1] <= 1'b0;
      end
    end
  end

  always_comb begin
    status_word = '0;
    status_word[DAO_ST_STATE_FIRST +: 4] = state_first;
    status_word[DAO_ST_STATE_SECOND +: 4] = state_second;
    status_word[DAO_ST_TWOS] = twos_fmt;
    status_word[DAO_ST_STAB] = stab_on;
    status_word[DAO_ST_SWAP] = swap_s;
    status_word[DAO_ST_OVR_FIRST] = ovr_hit_q[0];
    status_word[DAO_ST_OVR_SECOND] = ovr_hit_q[1];
  end

  // read data prepared in the address phase so it stands in the data phase
  always_comb begin
    rd_d = '0;
    case (haddr[7:0])
      DAO_REG_CTRL: rd_d[1:0] = fmt_q;
      DAO_REG_STATUS: rd_d = status_word;
      DAO_REG_RESULT_FIRST: rd_d = {15'h0000, ovr_first, 6'h00, res_first};
      DAO_REG_RESULT_SECOND: rd_d = {15'h0000, ovr_second, 6'h00, res_second};
      DAO_REG_COUNT: rd_d = {cnt_second_q, cnt_first_q};
      DAO_REG_ID: rd_d = DAO_ID_VALUE;
      default: rd_d = '0;
    endcase
  end

  // holds until the next read, so a late look still sees the word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (ap_valid && !hwrite) begin
      hrdata <= rd_d;
    end
  end
endmodule : dao_top

/* File: dao_pkg.sv */
// shared constants and types for the dual converter output port
package dao_pkg;
  localparam int DAO_RES_W = 10;
  localparam int DAO_IN_W = 12;
  localparam int DAO_LATENCY = 5;
  localparam int DAO_CNT_W = 16;
  // signed input range held by a 10-bit result
  localparam logic signed [DAO_IN_W-1:0] DAO_IN_MAX = 12'sh1ff;
  localparam logic signed [DAO_IN_W-1:0] DAO_IN_MIN = -12'sh200;
  localparam logic [DAO_IN_W-1:0] DAO_OB_OFFSET = 12'h200;
  // four-level format setting
  localparam logic [1:0] DAO_FMT_GND = 2'h0;
  localparam logic [1:0] DAO_FMT_THIRD = 2'h1;
  localparam logic [1:0] DAO_FMT_TWO_THIRDS = 2'h2;
  localparam logic [1:0] DAO_FMT_FULL = 2'h3;
  localparam logic [1:0] DAO_FMT_RESET = DAO_FMT_GND;
  // register byte offsets
  localparam logic [7:0] DAO_REG_CTRL = 8'h00;
  localparam logic [7:0] DAO_REG_STATUS = 8'h04;
  localparam logic [7:0] DAO_REG_RESULT_FIRST = 8'h08;
  localparam logic [7:0] DAO_REG_RESULT_SECOND = 8'h0c;
  localparam logic [7:0] DAO_REG_COUNT = 8'h10;
  localparam logic [7:0] DAO_REG_ID = 8'h14;
  // arbitrary identification value
  localparam logic [31:0] DAO_ID_VALUE = 32'h0000_d0a1;
  // status field positions
  localparam int DAO_ST_STATE_FIRST = 0;
  localparam int DAO_ST_STATE_SECOND = 4;
  localparam int DAO_ST_TWOS = 8;
  localparam int DAO_ST_STAB = 9;
  localparam int DAO_ST_SWAP = 10;
  localparam int DAO_ST_OVR_FIRST = 16;
  localparam int DAO_ST_OVR_SECOND = 17;
  localparam int DAO_RES_OVR_BIT = 16;
  localparam logic [1:0] DAO_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DAO_HRESP_OKAY = 2'h0;

  typedef enum logic [3:0] {
    DAO_ST_NORMAL = 4'b0001,
    DAO_ST_HIZ = 4'b0010,
    DAO_ST_NAP = 4'b0100,
    DAO_ST_SLEEP = 4'b1000
  } dao_state_t;
endpackage : dao_pkg

/* File: dao_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module dao_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : dao_sync

/* File: dao_chan.sv */
// one converter channel: power state, pipeline and code format
`timescale 1ns/1ps
module dao_chan
  import dao_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sample_pulse,
  input wire logic signed [DAO_IN_W-1:0] analog_code,
  input wire logic power_down,
  input wire logic output_enable_n,
  input wire logic twos_fmt,
  output logic [DAO_RES_W-1:0] result_q,
  output logic over_range_q,
  output logic drive,
  output logic converting,
  output dao_state_t state_q
);
  logic [DAO_LATENCY-1:0] valid_q;
  logic [DAO_RES_W-1:0] code_q [DAO_LATENCY];
  logic [DAO_LATENCY-1:0] ovr_q;
  logic [DAO_RES_W-1:0] ob_code;
  logic [DAO_IN_W-1:0] biased;
  logic in_ovr;
  dao_state_t state_d;

  always_comb begin
    case ({power_down, output_enable_n})
      2'b00: state_d = DAO_ST_NORMAL;
      2'b01: state_d = DAO_ST_HIZ;
      2'b10: state_d = DAO_ST_NAP;
      default: state_d = DAO_ST_SLEEP;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= DAO_ST_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  assign converting = (state_q == DAO_ST_NORMAL) || (state_q == DAO_ST_HIZ);
  // only the normal state drives the pins
  assign drive = (state_q == DAO_ST_NORMAL);

  always_comb begin
    in_ovr = (analog_code > DAO_IN_MAX) || (analog_code < DAO_IN_MIN);
    if (analog_code > DAO_IN_MAX) begin
      biased = DAO_IN_MAX + DAO_OB_OFFSET;
    end else if (analog_code < DAO_IN_MIN) begin
      biased = DAO_IN_MIN + DAO_OB_OFFSET;
    end else begin
      biased = analog_code + DAO_OB_OFFSET;
    end
    ob_code = biased[DAO_RES_W-1:0];
  end

  // five-stage pipeline stepped by sample edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_q <= '0;
      ovr_q <= '0;
      for (int i = 0; i < DAO_LATENCY; i++) begin
        code_q[i] <= '0;
      end
    end else if (state_q == DAO_ST_SLEEP) begin
      // sleep loses the pipeline contents; nap keeps them
      valid_q <= '0;
    end else if (converting && sample_pulse) begin
      // new sample on the rising edge
      valid_q <= {valid_q[DAO_LATENCY-2:0], 1'b1};
      ovr_q <= {ovr_q[DAO_LATENCY-2:0], in_ovr};
      code_q[0] <= ob_code;
      for (int i = 1; i < DAO_LATENCY; i++) begin
        code_q[i] <= code_q[i-1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= '0;
      over_range_q <= 1'b0;
    end else if (converting && sample_pulse && valid_q[DAO_LATENCY-1]) begin
      // top bit inverted for two's complement
      result_q <= twos_fmt ? {~code_q[DAO_LATENCY-1][DAO_RES_W-1], code_q[DAO_LATENCY-1][DAO_RES_W-2:0]}
                           : code_q[DAO_LATENCY-1];
      over_range_q <= ovr_q[DAO_LATENCY-1];
    end
  end
endmodule : dao_chan

/* File: dao_top_asserts.sv */
// concurrent checks on the dual converter output port pins
`timescale 1ns/1ps
module dao_top_asserts
  import dao_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic sample_clock_first,
  input wire logic sample_clock_second,
  input wire logic output_swap_select,
  input wire logic power_down_select_first,
  input wire logic power_down_select_second,
  input wire logic output_enable_n_first,
  input wire logic output_enable_n_second,
  input wire logic [DAO_RES_W-1:0] result_bus_first_o,
  input wire logic result_bus_first_oe,
  input wire logic over_range_flag_first_oe,
  input wire logic result_bus_second_oe
);
  logic pd1, pd2, on1, on2, sw;
  assign pd1 = power_down_select_first;
  assign pd2 = power_down_select_second;
  assign on1 = output_enable_n_first;
  assign on2 = output_enable_n_second;
  assign sw = output_swap_select;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // pins are synchronised, so twelve steady cycles cover the enable delay
  a_normal_drive: assert property ((!pd1 && !on1 && sw)[*8] ##1 (!pd1 && !on1 && sw)[*4] |-> result_bus_first_oe)
    else $error("bus first not driven in normal state");
  a_hiz_release: assert property ((!pd1 && on1 && sw)[*8] ##1 (!pd1 && on1 && sw)[*4] |-> !result_bus_first_oe)
    else $error("bus first driven with enable off");
  a_nap_release: assert property ((pd1 && !on1 && sw)[*8] ##1 (pd1 && !on1 && sw)[*4] |-> !result_bus_first_oe)
    else $error("bus first driven in nap");
  a_sleep_release: assert property ((pd1 && on1 && sw)[*8] ##1 (pd1 && on1 && sw)[*4] |-> !result_bus_first_oe)
    else $error("bus first driven in sleep");
  a_cross_drive: assert property ((!pd2 && !on2 && !sw)[*8] ##1 (!pd2 && !on2 && !sw)[*4] |-> result_bus_first_oe)
    else $error("crossed bus first not driven");
  a_straight_second: assert property ((pd2 && sw)[*8] ##1 (pd2 && sw)[*4] |-> !result_bus_second_oe)
    else $error("bus second driven while its channel is down");
  a_flag_pairs: assert property (over_range_flag_first_oe == result_bus_first_oe)
    else $error("flag enable differs from bus enable");
  a_bus_holds: assert property (($stable({sample_clock_first, sample_clock_second, sw, pd1, pd2}))[*8]
    |=> $stable(result_bus_first_o)) else $error("bus first changed with no sample edge");
  a_bus_okay: assert property (hreadyout && hresp == DAO_HRESP_OKAY)
    else $error("register bus not ready or not okay");
endmodule : dao_top_asserts

/* File: dao_capture.sv */
// capture logic model latching the shared output bus once per clock half
`timescale 1ns/1ps
module dao_capture
  import dao_pkg::*;
(
  input wire logic hclk,
  input wire logic share_clk,
  input wire logic [DAO_RES_W-1:0] bus_o,
  input wire logic bus_oe,
  output logic [DAO_RES_W-1:0] word_hi_q,
  output logic [DAO_RES_W-1:0] word_lo_q
);
  logic clk_q;
  logic [DAO_RES_W-1:0] line_q;
  logic [DAO_RES_W-1:0] line;
  // a released bus must not look like it still holds the last word
  assign line = bus_oe ? bus_o : ~line_q;
  always_ff @(posedge hclk) begin
    line_q <= line;
    clk_q <= share_clk;
    if (clk_q && !share_clk) word_hi_q <= line;
    if (!clk_q && share_clk) word_lo_q <= line;
  end
endmodule : dao_capture

/* File: tb_dao_top.sv */
// self-checking bench for the dual converter output port
`timescale 1ns/1ps
module tb_dao_top;
  import dao_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, clk1, clk2, swap, pd1, pd2, on1, on2, shared, twos;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [DAO_IN_W-1:0] code1, code2;
  logic [DAO_RES_W-1:0] bus1, bus2, cap_hi, cap_lo;
  logic oe1, oe2, of1, of2, ofe1, ofe2;
  logic [DAO_IN_W-1:0] h1[$], h2[$];
  int fails, cmp_count;
  assign hready = hreadyout;
  dao_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .sample_clock_first(clk1), .sample_clock_second(clk2), .analog_code_first(code1),
    .analog_code_second(code2), .output_swap_select(swap), .power_down_select_first(pd1),
    .power_down_select_second(pd2), .output_enable_n_first(on1), .output_enable_n_second(on2),
    .result_bus_first_o(bus1), .result_bus_first_oe(oe1), .over_range_flag_first_o(of1),
    .over_range_flag_first_oe(ofe1), .result_bus_second_o(bus2), .result_bus_second_oe(oe2),
    .over_range_flag_second_o(of2), .over_range_flag_second_oe(ofe2));
  dao_capture u_cap (.hclk, .share_clk(clk1), .bus_o(bus1), .bus_oe(oe1), .word_hi_q(cap_hi), .word_lo_q(cap_lo));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= DAO_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // {flag, word}: clamp to the 10-bit range, offset binary flips the sign bit
  function automatic logic [10:0] expv(input logic [DAO_IN_W-1:0] c, input logic tc);
    logic signed [DAO_IN_W-1:0] s;
    s = c;
    if (s > DAO_IN_MAX) return {1'b1, 10'h3ff ^ {tc, 9'h0}};
    if (s < DAO_IN_MIN) return {1'b1, 10'h000 ^ {tc, 9'h0}};
    return {1'b0, s[9:0] ^ {~tc, 9'h0}};
  endfunction : expv

  task samp(input logic [DAO_IN_W-1:0] a, input logic [DAO_IN_W-1:0] b);
    logic [10:0] e1, e2;
    code1 <= a;
    code2 <= b;
    h1.push_back(a);
    h2.push_back(b);
    repeat (2) @(posedge hclk);
    clk1 <= 1'b1;
    clk2 <= 1'b1;
    // swap select tied to the clocks
    if (shared) swap <= 1'b1;
    repeat (8) @(posedge hclk);
    clk1 <= 1'b0;
    clk2 <= 1'b0;
    if (shared) swap <= 1'b0;
    repeat (8) @(posedge hclk);
    if (shared || h1.size() < 6) return;
    e1 = expv(h1[h1.size()-6], twos);
    e2 = expv(h2[h2.size()-6], twos);
    if (swap) begin
      chk(32'({of1, bus1}), 32'(e1), "bus first straight");
      chk(32'({of2, bus2}), 32'(e2), "bus second straight");
    end else begin
      chk(32'({of1, bus1}), 32'(e2), "bus first crossed");
      chk(32'({of2, bus2}), 32'(e1), "bus second crossed");
    end
  endtask : samp

  task t_regs;
    ahb(DAO_REG_CTRL, 1'b0, 32'h0);
    chk(rd, 32'(DAO_FMT_RESET), "control reset value");
    ahb(DAO_REG_ID, 1'b0, 32'h0);
    chk(rd, DAO_ID_VALUE, "identity value");
    ahb(32'h0000_0040, 1'b1, 32'hffff_ffff);
    ahb(32'h0000_0040, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("register test done");
  endtask : t_regs

  task t_format;
    for (int f = 0; f < 4; f++) begin
      ahb(DAO_REG_CTRL, 1'b1, 32'(f));
      twos = (f >= 2);
      ahb(DAO_REG_CTRL, 1'b0, 32'h0);
      chk(rd, 32'(f), "format readback");
      ahb(DAO_REG_STATUS, 1'b0, 32'h0);
      chk(32'(rd[9:8]), 32'({f == 1 || f == 2, twos}), "format and stabilizer");
      for (int k = 0; k < 6; k++) samp(12'(37 * k + f - 200), 12'(300 - 53 * k));
    end
    $display("format test done");
  endtask : t_format

  task t_over;
    logic [DAO_IN_W-1:0] ta[6];
    logic [10:0] e;
    ta = '{12'h1ff, 12'h200, 12'he00, 12'hdff, 12'h2bc, 12'h000};
    swap <= 1'b0;
    for (int k = 0; k < 6; k++) samp(ta[k], ta[5 - k]);
    // five more samples push the over-range words out to the pins
    repeat (5) samp(12'h000, 12'h000);
    ahb(DAO_REG_STATUS, 1'b0, 32'h0);
    chk(32'(rd[DAO_ST_OVR_SECOND:DAO_ST_OVR_FIRST]), 32'h3, "sticky over-range seen");
    chk(32'(rd[DAO_ST_SWAP]), 32'h0, "synced swap low");
    ahb(DAO_REG_STATUS, 1'b1, (32'h1 << DAO_ST_OVR_FIRST) | (32'h1 << DAO_ST_OVR_SECOND));
    ahb(DAO_REG_STATUS, 1'b0, 32'h0);
    chk(32'(rd[DAO_ST_OVR_SECOND:DAO_ST_OVR_FIRST]), 32'h0, "sticky over-range cleared");
    e = expv(h2[h2.size()-6], twos);
    ahb(DAO_REG_RESULT_SECOND, 1'b0, 32'h0);
    chk(rd, (32'(e[10]) << DAO_RES_OVR_BIT) | 32'(e[9:0]), "result register second");
    ahb(DAO_REG_COUNT, 1'b0, 32'h0);
    chk(rd, {16'(h2.size()), 16'(h1.size())}, "conversion counts");
    swap <= 1'b1;
    $display("over-range test done");
  endtask : t_over

  task t_shared;
    shared = 1'b1;
    for (int k = 0; k < 7; k++) samp(12'h05a, 12'hf30);
    chk(32'(cap_hi), 32'(expv(12'h05a, twos)), "shared high half");
    chk(32'(cap_lo), 32'(expv(12'hf30, twos)), "shared low half");
    shared = 1'b0;
    swap <= 1'b1;
    repeat (8) @(posedge hclk);
    $display("shared bus test done");
  endtask : t_shared

  task t_power;
    for (int i = 0; i < 4; i++) begin
      {pd1, on1} <= 2'(i);
      {pd2, on2} <= 2'(i);
      repeat (14) @(posedge hclk);
      chk(32'({oe1, ofe1, oe2, ofe2}), 32'({4{i == 0}}), "output enables");
      ahb(DAO_REG_STATUS, 1'b0, 32'h0);
      chk(32'(rd[7:0]), 32'({2{4'(1 << i)}}), "channel states");
    end
    $display("power state test done");
  endtask : t_power

  initial begin
    repeat (5000) @(posedge hclk);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, clk1, clk2, pd1, pd2, on1, on2, shared, twos} = '0;
    swap = 1'b1;
    {haddr, hwdata, htrans, code1, code2} = '0;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_format();
    t_over();
    t_shared();
    t_power();
    test_done();
  end
endmodule : tb_dao_top

bind dao_top dao_top_asserts u_chk (.hclk, .hresetn, .hreadyout, .hresp, .sample_clock_first, .sample_clock_second,
  .output_swap_select, .power_down_select_first, .power_down_select_second, .output_enable_n_first,
  .output_enable_n_second, .result_bus_first_o, .result_bus_first_oe, .over_range_flag_first_oe,
  .result_bus_second_oe);
